// ### hdl/wrc_pkg.sv
package wrc_pkg;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_CMD    = 8'h04;
   localparam logic [7:0] REG_LOOPS  = 8'h08;
   localparam logic [7:0] REG_SEGSZ  = 8'h0C;
   localparam logic [7:0] REG_LEN    = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam logic [7:0] REG_MADDR  = 8'h18;
   localparam logic [7:0] REG_MDATA  = 8'h1C;
   localparam logic [7:0] REG_SADDR  = 8'h20;
   localparam logic [7:0] REG_SDATA  = 8'h24;
   // Control field positions
   localparam int CT_MODE = 0;
   localparam int CT_TSEL = 3;
   localparam int CT_GLVL = 5;
   localparam int CT_SYNC = 6;
   localparam int CT_E0K  = 7;
   localparam int CT_E1L  = 9;
   // Command bits
   localparam int CM_ARM  = 0;
   localparam int CM_TRG  = 1;
   localparam int CM_STOP = 2;
   localparam int CM_SW   = 3;
   localparam int CM_TGT  = 4;
   // Sequence entry field positions
   localparam int SQ_BASE = 0;
   localparam int SQ_LAST = 8;
   localparam int SQ_LOOP = 16;
   localparam int SQ_COND = 24;
   localparam int SQ_NEXT = 26;
   localparam int SQ_END  = 30;
   // Status field positions
   localparam int SS_ST   = 0;
   localparam int SS_REQ  = 2;
   localparam int SS_FULL = 3;
   localparam int SS_ADDR = 8;
   localparam int SS_FCNT = 16;
   // Values after reset and sizes
   localparam logic [15:0] CTRL_RST  = 16'h0000;
   localparam logic [15:0] LOOPS_RST = 16'h0001;
   localparam logic [7:0]  SEGSZ_RST = 8'h0F;
   localparam logic [7:0]  LEN_RST   = 8'hFF;
   localparam logic [8:0]  FIFO_CAP  = 9'h100;
   localparam logic [8:0]  FIFO_LOW  = 9'h080;
   localparam logic [1:0]  RESP_OK   = 2'h0;
   localparam logic [1:0]  RESP_ERR  = 2'h2;
   typedef enum logic [2:0] {
      M_SINGLE, M_REPEAT, M_RESTART, M_FIFO, M_MULTI, M_GATED, M_SEQ
   } wrc_mode_t;
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_PLAY, ST_WAIT} wrc_st_t;
endpackage

// ### hdl/wrc_top.sv
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Contract
// - singleshot plays whole waveform once, stops
// - later triggers ignored once run started
// - repeated replay for loop count or forever
// - start trigger: external input or software
// - restart mode plays once per trigger
// - restart trigger: external or software
// - FIFO mode uses whole memory circularly
// - FIFO raises refill request, host refills
// - multiple replay uses equal-size segments
// - each trigger plays next segment
// - gated replay advances only on active gate
// - sequence plays segments in the order of the entries' next links
// - each entry repeats its segment loop times
// - entry trigger condition gates advancing
// - software command switches sequence waveform
// - memory writable while other segments play
// - sequence triggers/switch only when standalone
// - first trigger: edge, window, hysteresis, rearm
// - second trigger: edge or level only
module wrc_top (
   input  wire  logic        REF_CLK,
   input  wire  logic        RST,
   input  wire  logic [7:0]  S_AXI_AWADDR,
   input  wire  logic        S_AXI_AWVALID,
   output logic              S_AXI_AWREADY,
   input  wire  logic [31:0] S_AXI_WDATA,
   input  wire  logic [3:0]  S_AXI_WSTRB,
   input  wire  logic        S_AXI_WVALID,
   output logic              S_AXI_WREADY,
   output logic [1:0]        S_AXI_BRESP,
   output logic              S_AXI_BVALID,
   input  wire  logic        S_AXI_BREADY,
   input  wire  logic [7:0]  S_AXI_ARADDR,
   input  wire  logic        S_AXI_ARVALID,
   output logic              S_AXI_ARREADY,
   output logic [31:0]       S_AXI_RDATA,
   output logic [1:0]        S_AXI_RRESP,
   output logic              S_AXI_RVALID,
   input  wire  logic        S_AXI_RREADY,
   input  wire  logic        EXT0_HI,
   input  wire  logic        EXT0_LO,
   input  wire  logic        EXT1_CMP,
   input  wire  logic        GATE_IN,
   output logic [15:0]       DAC_DATA,
   output logic              DAC_VALID,
   output logic              STREAM_REQ,
   output logic              RUN_ACTIVE
);
   import wrc_pkg::*;

   typedef struct packed {
      logic              aw_ok;
      logic              w_ok;
      logic [7:0]        awa;
      logic [31:0]       wd;
      logic [3:0]        ws;
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [31:0]       rdata;
      logic [15:0]       ctrl;
      logic [15:0]       loops;
      logic [7:0]        segsz;
      logic [7:0]        len;
      logic [7:0]        maddr;
      logic [3:0]        saddr;
      logic [1:0]        e0h;
      logic [1:0]        e0l;
      logic [1:0]        e1;
      logic [1:0]        gt;
      logic              ph;
      logic              pw;
      logic              p1;
      logic              hy;
      logic              ra;
      wrc_st_t           st;
      logic [7:0]        base;
      logic [7:0]        pos;
      logic [15:0]       lcnt;
      logic [3:0]        sidx;
      logic [7:0]        addr;
      logic [7:0]        wptr;
      logic [8:0]        fcnt;
      logic [15:0]       dac;
      logic              dval;
      logic              sreq;
      logic              run;
   } wrc_state_t;

   wrc_state_t  s_q;
   wrc_state_t  s_d;
   logic [15:0] smem [256];
   logic [30:0] qmem [16];
   logic        mem_we;
   logic [7:0]  mem_wa;
   logic [15:0] mem_wd;
   logic        seq_we;
   logic [30:0] seq_wd;

   // Byte-lane merge of write data into the old register value
   function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] v, input logic [3:0] b);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (b[i]) begin
            r[i*8 +: 8] = v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      logic        wr;
      logic [31:0] wv;
      logic        arm;
      logic        strg;
      logic        stop;
      logic        swc;
      logic        push;
      logic        pop;
      logic        hi;
      logic        lo;
      logic        c1;
      logic        win;
      logic        e0;
      logic        e1;
      logic        trg;
      logic        solo;
      logic        gate;
      logic        adv;
      logic        cev;
      logic        last;
      logic        done;
      logic [30:0] ent;
      logic [7:0]  slast;
      logic [7:0]  ql;
      logic [8:0]  nb;
      logic [7:0]  ra;
      wrc_mode_t   md;
      s_d    = s_q;
      mem_we = 1'b0;
      mem_wa = s_q.maddr;
      mem_wd = s_q.wd[15:0];
      seq_we = 1'b0;
      seq_wd = s_q.wd[30:0];
      wv     = 32'h0000_0000;
      arm    = 1'b0;
      strg   = 1'b0;
      stop   = 1'b0;
      swc    = 1'b0;
      push   = 1'b0;
      pop    = 1'b0;
      adv    = 1'b0;
      last   = 1'b0;
      done   = 1'b0;
      cev    = 1'b0;
      win    = 1'b0;
      e0     = 1'b0;
      e1     = 1'b0;
      trg    = 1'b0;
      slast  = 8'h00;
      ql     = 8'h00;
      nb     = 9'h000;
      ra     = 8'h00;
      md     = wrc_mode_t'(s_q.ctrl[CT_MODE +: 3]);
      solo   = !s_q.ctrl[CT_SYNC];
      ent    = qmem[s_q.sidx];

      // Two-stage synchronisers for pins
      s_d.e0h = {s_q.e0h[0], EXT0_HI};
      s_d.e0l = {s_q.e0l[0], EXT0_LO};
      s_d.e1  = {s_q.e1[0], EXT1_CMP};
      s_d.gt  = {s_q.gt[0], GATE_IN};
      hi      = s_q.e0h[1];
      lo      = s_q.e0l[1];
      c1      = s_q.e1[1];
      gate    = s_q.gt[1] == s_q.ctrl[CT_GLVL];

      // AXI write channels are taken in either order
      if (S_AXI_AWVALID && s_q.awready) begin
         s_d.aw_ok = 1'b1;
         s_d.awa   = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && s_q.wready) begin
         s_d.w_ok = 1'b1;
         s_d.wd   = S_AXI_WDATA;
         s_d.ws   = S_AXI_WSTRB;
      end
      if (s_q.bvalid && S_AXI_BREADY) begin
         s_d.bvalid = 1'b0;
      end
      wr = s_q.aw_ok && s_q.w_ok && !s_q.bvalid;
      if (wr) begin
         s_d.aw_ok  = 1'b0;
         s_d.w_ok   = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp  = RESP_OK;
         case ({s_q.awa[7:2], 2'b00})
            REG_CTRL: begin
               if (s_q.st == ST_IDLE) begin
                  wv        = wmerge({16'h0000, s_q.ctrl}, s_q.wd, s_q.ws);
                  s_d.ctrl  = wv[15:0];
               end
            end
            REG_CMD: begin
               wv   = wmerge(32'h0000_0000, s_q.wd, s_q.ws);
               arm  = wv[CM_ARM];
               strg = wv[CM_TRG];
               stop = wv[CM_STOP];
               swc  = wv[CM_SW];
            end
            REG_LOOPS: begin
               wv        = wmerge({16'h0000, s_q.loops}, s_q.wd, s_q.ws);
               s_d.loops = wv[15:0];
            end
            REG_SEGSZ: begin
               wv        = wmerge({24'h000000, s_q.segsz}, s_q.wd, s_q.ws);
               s_d.segsz = wv[7:0];
            end
            REG_LEN: begin
               wv      = wmerge({24'h000000, s_q.len}, s_q.wd, s_q.ws);
               s_d.len = wv[7:0];
            end
            REG_MADDR: begin
               wv        = wmerge({24'h000000, s_q.maddr}, s_q.wd, s_q.ws);
               s_d.maddr = wv[7:0];
            end
            REG_MDATA: begin
               if (md == M_FIFO) begin
                  push = 1'b1;
               end else begin
                  mem_we    = 1'b1;
                  s_d.maddr = s_q.maddr + 8'h01;
               end
            end
            REG_SADDR: begin
               wv        = wmerge({28'h0000000, s_q.saddr}, s_q.wd, s_q.ws);
               s_d.saddr = wv[3:0];
            end
            REG_SDATA: begin
               seq_we    = 1'b1;
               s_d.saddr = s_q.saddr + 4'h1;
            end
            default: s_d.bresp = RESP_ERR;
         endcase
      end
      s_d.awready = !s_d.aw_ok && !s_d.bvalid;
      s_d.wready  = !s_d.w_ok && !s_d.bvalid;

      // AXI read channel
      if (s_q.rvalid && S_AXI_RREADY) begin
         s_d.rvalid  = 1'b0;
         s_d.arready = 1'b1;
      end
      if (S_AXI_ARVALID && s_q.arready) begin
         s_d.rvalid  = 1'b1;
         s_d.arready = 1'b0;
         s_d.rresp   = RESP_OK;
         s_d.rdata   = 32'h0000_0000;
         case ({S_AXI_ARADDR[7:2], 2'b00})
            REG_CTRL:  s_d.rdata[15:0] = s_q.ctrl;
            REG_CMD:   s_d.rdata = 32'h0000_0000;
            REG_LOOPS: s_d.rdata[15:0] = s_q.loops;
            REG_SEGSZ: s_d.rdata[7:0] = s_q.segsz;
            REG_LEN:   s_d.rdata[7:0] = s_q.len;
            REG_STATUS: begin
               s_d.rdata[SS_ST +: 2]   = s_q.st;
               s_d.rdata[SS_REQ]       = s_q.sreq;
               s_d.rdata[SS_FULL]      = s_q.fcnt == FIFO_CAP;
               s_d.rdata[SS_ADDR +: 8] = (md == M_FIFO) ? s_q.addr : s_q.base + s_q.pos;
               s_d.rdata[SS_FCNT +: 9] = s_q.fcnt;
            end
            REG_MADDR: s_d.rdata[7:0] = s_q.maddr;
            REG_MDATA: s_d.rdata[15:0] = smem[s_q.maddr];
            REG_SADDR: s_d.rdata[3:0] = s_q.saddr;
            REG_SDATA: s_d.rdata[30:0] = qmem[s_q.saddr];
            default:   s_d.rresp = RESP_ERR;
         endcase
      end

      // First trigger input: two comparators, four detectors
      win    = hi || !lo;
      s_d.ph = hi;
      s_d.pw = win;
      s_d.p1 = c1;
      s_d.hy = hi ? 1'b1 : (!lo ? 1'b0 : s_q.hy);
      case (s_q.ctrl[CT_E0K +: 2])
         2'd0:    e0 = hi && !s_q.ph;
         2'd1:    e0 = win && !s_q.pw;
         2'd2:    e0 = s_d.hy && !s_q.hy;
         default: e0 = hi && !s_q.ph && s_q.ra;
      endcase
      s_d.ra = !lo ? 1'b1 : ((hi && !s_q.ph) ? 1'b0 : s_q.ra);
      // Second trigger input: edge or level only
      e1 = s_q.ctrl[CT_E1L] ? c1 : (c1 && !s_q.p1);
      case (s_q.ctrl[CT_TSEL +: 2])
         2'd0:    trg = strg;
         2'd1:    trg = e0;
         default: trg = e1;
      endcase

      // Segment window for the active mode
      ql    = ent[SQ_LOOP +: 8];
      slast = s_q.len;
      if (md == M_MULTI) begin
         slast = s_q.segsz;
      end else if (md == M_SEQ) begin
         slast = ent[SQ_LAST +: 8];
      end
      case (ent[SQ_COND +: 2])
         2'd0:    cev = 1'b1;
         2'd1:    cev = strg;
         2'd2:    cev = e0;
         default: cev = e1;
      endcase
      cev = cev || !solo;
      nb  = {1'b0, s_q.base} + {1'b0, s_q.segsz} + 9'h001;

      // Replay engine
      case (s_q.st)
         ST_IDLE: begin
            if (arm) begin
               s_d.pos  = 8'h00;
               s_d.lcnt = 16'h0000;
               s_d.sidx = 4'h0;
               s_d.base = 8'h00;
               if (md == M_FIFO || md == M_GATED) begin
                  s_d.st = ST_PLAY;
               end else if (md == M_SEQ) begin
                  s_d.st   = ST_PLAY;
                  s_d.base = qmem[4'h0][SQ_BASE +: 8];
               end else begin
                  s_d.st = ST_ARMED;
               end
            end
         end
         ST_ARMED: begin
            if (trg) begin
               s_d.st = ST_PLAY;
            end
         end
         ST_PLAY: begin
            if (md == M_FIFO) begin
               pop = s_q.fcnt != 9'h000;
            end else if (md == M_GATED) begin
               adv = gate;
            end else begin
               adv = 1'b1;
            end
            if (adv) begin
               s_d.pos = s_q.pos + 8'h01;
               last    = s_q.pos == slast;
            end
            if (last) begin
               s_d.pos  = 8'h00;
               s_d.lcnt = s_q.lcnt + 16'h0001;
               case (md)
                  M_SINGLE: s_d.st = ST_IDLE;
                  M_REPEAT: begin
                     if (s_q.loops != 16'h0000 && s_d.lcnt == s_q.loops) begin
                        s_d.st = ST_IDLE;
                     end
                  end
                  M_RESTART: s_d.st = ST_ARMED;
                  M_MULTI: begin
                     s_d.st   = ST_ARMED;
                     s_d.base = (nb + {1'b0, s_q.segsz} > {1'b0, s_q.len}) ? 8'h00 : nb[7:0];
                  end
                  M_SEQ: begin
                     if (s_d.lcnt >= {8'h00, ql}) begin
                        s_d.lcnt = 16'h0000;
                        if (ent[SQ_COND +: 2] != 2'd0 && solo) begin
                           s_d.st = ST_WAIT;
                        end else begin
                           done = 1'b1;
                        end
                     end
                  end
                  default: s_d.pos = 8'h00;
               endcase
            end
         end
         ST_WAIT: begin
            done = cev;
         end
         default: s_d.st = ST_IDLE;
      endcase
      // Move to the next sequence entry
      if (done) begin
         s_d.st   = ent[SQ_END] ? ST_IDLE : ST_PLAY;
         s_d.sidx = ent[SQ_NEXT +: 4];
         s_d.base = qmem[ent[SQ_NEXT +: 4]][SQ_BASE +: 8];
      end
      // Software waveform switch in sequence mode
      if (swc && md == M_SEQ && solo && s_q.st != ST_IDLE) begin
         s_d.st   = ST_PLAY;
         s_d.sidx = wv[CM_TGT +: 4];
         s_d.base = qmem[wv[CM_TGT +: 4]][SQ_BASE +: 8];
         s_d.pos  = 8'h00;
         s_d.lcnt = 16'h0000;
      end

      // Circular buffer pointers
      if (push && (s_q.fcnt != FIFO_CAP || pop)) begin
         mem_we   = 1'b1;
         mem_wa   = s_q.wptr;
         s_d.wptr = s_q.wptr + 8'h01;
      end
      if (pop) begin
         s_d.addr = s_q.addr + 8'h01;
      end
      s_d.fcnt = s_q.fcnt + {8'h00, mem_we && md == M_FIFO} - {8'h00, pop};

      // Stop wins over every other transition
      if (stop) begin
         s_d.st   = ST_IDLE;
         s_d.fcnt = 9'h000;
         s_d.wptr = 8'h00;
         s_d.addr = 8'h00;
         adv      = 1'b0;
         pop      = 1'b0;
      end

      // Output sample and status
      ra        = (md == M_FIFO) ? s_q.addr : s_q.base + s_q.pos;
      s_d.dac   = smem[ra];
      s_d.dval  = adv || pop;
      s_d.sreq  = s_d.st == ST_PLAY && md == M_FIFO && s_d.fcnt <= FIFO_LOW;
      s_d.run   = s_d.st != ST_IDLE;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         s_q         <= '0;
         s_q.ctrl    <= CTRL_RST;
         s_q.loops   <= LOOPS_RST;
         s_q.segsz   <= SEGSZ_RST;
         s_q.len     <= LEN_RST;
         s_q.awready <= 1'b1;
         s_q.wready  <= 1'b1;
         s_q.arready <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Sample and sequence memories
   always_ff @(posedge REF_CLK) begin
      if (mem_we) begin
         smem[mem_wa] <= mem_wd;
      end
      if (seq_we) begin
         qmem[s_q.saddr] <= seq_wd;
      end
   end

   // Outputs straight from the state register
   assign S_AXI_AWREADY = s_q.awready;
   assign S_AXI_WREADY  = s_q.wready;
   assign S_AXI_BRESP   = s_q.bresp;
   assign S_AXI_BVALID  = s_q.bvalid;
   assign S_AXI_ARREADY = s_q.arready;
   assign S_AXI_RDATA   = s_q.rdata;
   assign S_AXI_RRESP   = s_q.rresp;
   assign S_AXI_RVALID  = s_q.rvalid;
   assign DAC_DATA      = s_q.dac;
   assign DAC_VALID     = s_q.dval;
   assign STREAM_REQ    = s_q.sreq;
   assign RUN_ACTIVE    = s_q.run;
endmodule

// ### tb/tb_waveform_replay_controller.sv
`timescale 1ns/1ps
module tb_waveform_replay_controller;
   import wrc_pkg::*;
   logic        clk, rst, awv, wv, bry, arv, rry, awr, wr_r, bv, arr, rv, dv, sreq, run;
   logic        e0h, e0l, e1, gt, lag, hi_p, lo_p, e1_p, gt_p;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rdat;
   logic [1:0]  bresp, rresp;
   logic [15:0] dd;
   logic [15:0] got[$];
   logic [15:0] exp[$];
   int          bad_count, total_checks, seed, mem[16], n;

   wrc_top uut (
      .REF_CLK(clk), .RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
      .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
      .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .EXT0_HI(e0h),
      .EXT0_LO(e0l), .EXT1_CMP(e1), .GATE_IN(gt), .DAC_DATA(dd), .DAC_VALID(dv), .STREAM_REQ(sreq),
      .RUN_ACTIVE(run));
   wrc_src_model src (.clk(clk), .lag(lag), .hi_req(hi_p), .lo_req(lo_p), .e1_req(e1_p), .gate_req(gt_p),
      .hi(e0h), .lo(e0l), .e1(e1), .gate(gt));

   ////////////////////////////////////////////////////////////////////////////
   // Clock and sample monitor
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (dv === 1'b1) got.push_back(dd);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checking and bus tasks
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic test_done();
      if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OK);
      logic ad, dn;
      ad = 0;
      dn = 0;
      @(posedge clk);
      awa <= a;
      wd  <= d;
      awv <= 1;
      wv  <= 1;
      bry <= 1;
      while (!(ad && dn)) begin
         @(posedge clk);
         if (awr === 1'b1 && !ad) begin
            ad = 1;
            awv <= 0;
         end
         if (wr_r === 1'b1 && !dn) begin
            dn = 1;
            wv <= 0;
         end
      end
      do @(posedge clk); while (bv !== 1'b1);
      bry <= 0;
      chk(bresp, er);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OK);
      @(posedge clk);
      ara <= a;
      arv <= 1;
      rry <= 1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 0;
      do @(posedge clk); while (rv !== 1'b1);
      rry <= 0;
      chk(rdat, e);
      chk(rresp, er);
   endtask
   task automatic wait_idle();
      repeat (2) @(posedge clk);
      do @(posedge clk); while (run !== 1'b0);
      repeat (3) @(posedge clk);
   endtask
   task automatic cmpq();
      chk(got.size(), exp.size());
      foreach (exp[i]) chk(got[i], exp[i]);
      got.delete();
      exp.delete();
   endtask
   task automatic play(input int base, input int cnt);
      for (int i = 0; i < cnt; i++) exp.push_back(mem[base + i]);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      test_done();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {rst, awv, wv, bry, arv, rry, lag, hi_p, e1_p, gt_p} = 10'h200;
      lo_p = 1;
      awa = 0;
      ara = 0;
      wd = 0;
      seed = 32'h5bd55b45;
      repeat (10) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      chk({awr, wr_r, arr, bv, rv, run, sreq}, 7'h70);
      rc(REG_CTRL, 0);
      rc(REG_LOOPS, 1);
      rc(REG_SEGSZ, 32'h0F);
      rc(REG_LEN, 32'hFF);
      rc(REG_CMD, 0);
      rc(8'h30, 0, RESP_ERR);
      wr(8'h30, 1, RESP_ERR);
      wr(REG_MADDR, 0);
      for (int i = 0; i < 16; i++) begin
         mem[i] = $random(seed) & 16'hFFFF;
         wr(REG_MDATA, mem[i]);
      end
      wr(REG_LEN, 15);
      wr(REG_LOOPS, 2);
      // Singleshot then repeated, extra triggers while playing
      for (int m = 0; m < 2; m++) begin
         wr(REG_CTRL, m);
         wr(REG_CMD, 1 << CM_ARM);
         wr(REG_CMD, 1 << CM_TRG);
         wr(REG_CMD, 1 << CM_TRG);
         wait_idle();
         for (int l = 0; l <= m; l++) play(0, 16);
         cmpq();
      end
      // First trigger input, every detection kind
      for (int k = 0; k < 4; k++) begin
         hi_p <= 0;
         lo_p <= 1;
         lag <= k[0];
         wr(REG_CTRL, (k << CT_E0K) | (1 << CT_TSEL));
         wr(REG_CMD, 1 << CM_ARM);
         lo_p <= 0;
         repeat (5) @(posedge clk);
         lo_p <= 1;
         repeat (5) @(posedge clk);
         hi_p <= 1;
         wait_idle();
         play(0, 16);
         cmpq();
      end
      // Restart on second input edges
      wr(REG_CTRL, 2 | (2 << CT_TSEL));
      wr(REG_CMD, 1 << CM_ARM);
      repeat (2) begin
         e1_p <= 1;
         repeat (4) @(posedge clk);
         e1_p <= 0;
         repeat (40) @(posedge clk);
         play(0, 16);
      end
      wr(REG_CMD, 1 << CM_STOP);
      cmpq();
      // Multiple replay, wrap after last segment
      wr(REG_SEGSZ, 3);
      wr(REG_CTRL, 4);
      wr(REG_CMD, 1 << CM_ARM);
      for (int t = 0; t < 5; t++) begin
         wr(REG_CMD, 1 << CM_TRG);
         repeat (12) @(posedge clk);
         play((t % 4) * 4, 4);
      end
      wr(REG_CMD, 1 << CM_STOP);
      cmpq();
      // Gated replay, mode write refused while running
      wr(REG_CTRL, 5 | (1 << CT_GLVL));
      wr(REG_CMD, 1 << CM_ARM);
      repeat (20) @(posedge clk);
      chk(got.size(), 0);
      gt_p <= 1;
      repeat (9) @(posedge clk);
      gt_p <= 0;
      repeat (10) @(posedge clk);
      wr(REG_CTRL, 0);
      rc(REG_CTRL, 5 | (1 << CT_GLVL));
      wr(REG_CMD, 1 << CM_STOP);
      n = got.size();
      chk(n, 9);
      for (int i = 0; i < n; i++) exp.push_back(mem[i % 16]);
      cmpq();
      // Streaming refill request
      wr(REG_CTRL, 3);
      wr(REG_CMD, 1 << CM_ARM);
      repeat (4) @(posedge clk);
      chk(sreq, 1);
      for (int i = 0; i < 4; i++) wr(REG_MDATA, mem[i]);
      play(0, 4);
      wr(REG_CMD, 1 << CM_STOP);
      repeat (3) @(posedge clk);
      chk({sreq, run}, 0);
      cmpq();
      // Sequence: entry 0 twice, then entry 1 once and end
      wr(REG_SADDR, 0);
      wr(REG_SDATA, 32'h0402_0100);
      wr(REG_SADDR, 1);
      wr(REG_SDATA, 32'h4001_0104);
      wr(REG_CTRL, 6);
      wr(REG_CMD, 1 << CM_ARM);
      wait_idle();
      play(0, 2);
      play(0, 2);
      play(4, 2);
      cmpq();
      // Sequence: condition wait, switch, synced skips wait
      wr(REG_SADDR, 0);
      wr(REG_SDATA, 32'h0500_0108);
      for (int y = 0; y < 2; y++) begin
         wr(REG_CTRL, 6 | (y << CT_SYNC));
         wr(REG_CMD, 1 << CM_ARM);
         repeat (20) @(posedge clk);
         play(8, 2);
         if (y == 0) begin
            cmpq();
            wr(REG_CMD, (1 << CM_SW) | (1 << CM_TGT));
         end
         wait_idle();
         play(4, 2);
         cmpq();
      end
      test_done();
   end
endmodule

// ### tb/wrc_src_model.sv
`timescale 1ns/1ps
module wrc_src_model (
   input  wire logic clk,
   input  wire logic lag,
   input  wire logic hi_req,
   input  wire logic lo_req,
   input  wire logic e1_req,
   input  wire logic gate_req,
   output logic      hi,
   output logic      lo,
   output logic      e1,
   output logic      gate
);
   logic [3:0] stage_q;
   logic [3:0] pins_q;

   // Pins follow requests one clock later, two when slow
   always_ff @(posedge clk) begin
      stage_q <= {hi_req, lo_req, e1_req, gate_req};
      pins_q  <= lag ? stage_q : {hi_req, lo_req, e1_req, gate_req};
   end
   assign {hi, lo, e1, gate} = pins_q;
endmodule

// ### tb/wrc_top_properties.sv
`timescale 1ns/1ps
module wrc_chk
   import wrc_pkg::*;
(
   input wire logic        REF_CLK,
   input wire logic        RST,
   input wire logic [7:0]  S_AXI_AWADDR,
   input wire logic        S_AXI_AWVALID,
   input wire logic        S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0]  S_AXI_WSTRB,
   input wire logic        S_AXI_WVALID,
   input wire logic        S_AXI_WREADY,
   input wire logic [1:0]  S_AXI_BRESP,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic        S_AXI_RVALID,
   input wire logic        DAC_VALID,
   input wire logic        STREAM_REQ,
   input wire logic        RUN_ACTIVE
);
   logic wr_take;

   // Both halves of a write taken at one edge
   assign wr_take = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   ////////////////////////////////////////////////////////////////////////////
   // Replay behaviour
   chk_dac_idle:
      assert property (!RUN_ACTIVE && $past(!RUN_ACTIVE) |-> !DAC_VALID) else $error("sample while idle");
   chk_stream_run:
      assert property (STREAM_REQ |-> RUN_ACTIVE) else $error("refill request while idle");
   chk_stop_cmd:
      assert property (wr_take && S_AXI_AWADDR == REG_CMD && S_AXI_WSTRB[0] && S_AXI_WDATA[CM_STOP]
         |-> ##[1:4] !RUN_ACTIVE) else $error("stop did not end replay");

   ////////////////////////////////////////////////////////////////////////////
   // Register bus
   chk_bad_addr:
      assert property (wr_take && S_AXI_AWADDR >= 8'h28 |-> ##[1:2] S_AXI_BVALID && S_AXI_BRESP == RESP_ERR)
         else $error("unmapped write not refused");
   chk_b_latency:
      assert property (wr_take |-> ##[1:2] S_AXI_BVALID) else $error("write response late");
   chk_r_latency:
      assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read data late");
   chk_b_block:
      assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY) else $error("write taken with B pending");
   chk_r_block:
      assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("read taken with R pending");

   // Main scenarios
   cover property (DAC_VALID && RUN_ACTIVE);
   cover property (STREAM_REQ);
   cover property (S_AXI_BVALID && S_AXI_BRESP == RESP_ERR);
endmodule

bind wrc_top wrc_chk u_chk (
   .REF_CLK(REF_CLK), .RST(RST), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
   .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
   .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RVALID(S_AXI_RVALID), .DAC_VALID(DAC_VALID), .STREAM_REQ(STREAM_REQ), .RUN_ACTIVE(RUN_ACTIVE)
);
